// >>> src/crossbar_pkg.sv
// Constants for the priority crossbar and its port pins.
// Assumes a 32-bit APB register bus and four 8-bit ports.
package crossbar_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 4;
    localparam int ROUTED_PORTS = 3;
    localparam int NUM_PINS = NUM_PORTS * PORT_W;
    localparam int ROUTED_PINS = ROUTED_PORTS * PORT_W;
    localparam int NUM_SIG = 23;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 5;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_ROUTE_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_C = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DRIVE_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LATCH_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h04;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int A_SMBUS = 0;
    localparam int A_SPI = 1;
    localparam int A_UART = 2;
    localparam int A_PCA_LSB = 3;
    localparam int A_ECI = 6;
    localparam int A_CP0 = 7;
    localparam int C_XBAR_EN = 6;
    localparam int C_WPU_DIS = 7;
    localparam int PCA_W = 3;
    localparam logic [PCA_W-1:0] PCA_MAX = 3'h5;

    // ----------------------------------------------------------------
    // Signal slots in priority order
    // ----------------------------------------------------------------
    localparam int SIG_SDA = 0;
    localparam int SIG_SCL = 1;
    localparam int SIG_SPI_FIRST = 2;
    localparam int SIG_SPI_LAST = 5;
    localparam int SIG_TX = 6;
    localparam int SIG_RX = 7;
    localparam int SIG_CEX0 = 8;
    localparam int SIG_CEX_LAST = 12;
    localparam int SIG_ECI = 13;
    localparam int SIG_CP0 = 14;
    localparam int SIG_B_FIRST = 15;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [PORT_W-1:0] ROUTE_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DRIVE_RESET = 8'h00;
    localparam logic [PORT_W-1:0] LATCH_RESET = 8'hff;
    localparam logic IDLE_LEVEL = 1'b1;

endpackage : crossbar_pkg

// >>> src/pin_sync.sv
// Two-stage synchroniser for a bus of independent pin levels.
// Assumes each bit is a level with no relation to its neighbours.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule : pin_sync

`default_nettype wire

// >>> src/priority_crossbar_port_io.sv
// Priority crossbar, port drive control and APB register file.
// Assumes pins are sampled asynchronously and peripherals share pclk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - SMBus first, on port 0 bits 0-1
// - Fill pins low to high, ports 0-2
// - Unselected functions skipped, no gaps left
// - Serial bus signals routed as group
// - Leftover pins are contiguous general I/O
// - Latch read returns live pin level
// - Routing active only with global enable
// - Disabled crossbar leaves all pins inputs
// - Drive mode set by drive config bit
// - SMBus and mode-0 RX forced open-drain
// - Weak pull-up on open-drain pins
// - Pull-up disable ignores push-pull pins
// - Pull-up off while pin drives low
// - Unbonded pins unreachable, order kept
// - Fourth port is general I/O only
module priority_crossbar_port_io
    import crossbar_pkg::*;
#(
    parameter int BONDED_PORTS = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [crossbar_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crossbar_pkg::DATA_W-1:0] pwdata,
    output logic [crossbar_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_in,
    output logic [crossbar_pkg::NUM_PINS-1:0] pin_out,
    output logic [crossbar_pkg::NUM_PINS-1:0] pin_oe,
    output logic [crossbar_pkg::NUM_PINS-1:0] pin_pullup,
    // Peripheral side
    input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_out,
    input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_drive,
    input wire logic uart_mode0,
    output logic [crossbar_pkg::NUM_SIG-1:0] periph_in
);
    import crossbar_pkg::*;

    // Refuse parameters the logic cannot serve
    if (BONDED_PORTS < 1 || BONDED_PORTS > NUM_PORTS) begin : g_bad_bonded
        $error("BONDED_PORTS must lie between 1 and 4");
    end
    if (NUM_SIG > 2 ** POS_W) begin : g_bad_slot_w
        $error("signal slot index too narrow");
    end

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Selection of one signal slot from the routing registers
    function automatic logic sig_enable(input logic [PORT_W-1:0] ra,
                                        input logic [PORT_W-1:0] rb,
                                        input int idx);
        logic [PCA_W-1:0] pca;
        pca = ra[A_PCA_LSB +: PCA_W];
        if (pca > PCA_MAX) begin
            pca = '0;
        end
        if (idx <= SIG_SCL) begin
            sig_enable = ra[A_SMBUS];
        end else if (idx <= SIG_SPI_LAST) begin
            sig_enable = ra[A_SPI];
        end else if (idx <= SIG_RX) begin
            sig_enable = ra[A_UART];
        end else if (idx <= SIG_CEX_LAST) begin
            sig_enable = (32'(pca) > (idx - SIG_CEX0));
        end else if (idx == SIG_ECI) begin
            sig_enable = ra[A_ECI];
        end else if (idx == SIG_CP0) begin
            sig_enable = ra[A_CP0];
        end else begin
            sig_enable = rb[idx - SIG_B_FIRST];
        end
    endfunction : sig_enable

    // Signals whose pin is open-drain whatever the drive config says
    function automatic logic forced_od(input int idx, input logic mode0);
        forced_od = (idx == SIG_SDA) || (idx == SIG_SCL) ||
                    ((idx == SIG_RX) && mode0);
    endfunction : forced_od

    // Register index of a drive or latch byte, or -1 when unmapped
    function automatic int port_slot(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] base);
        port_slot = -1;
        for (int k = 0; k < NUM_PORTS; k++) begin
            if (addr == base + ADDR_W'(k) * OFF_STRIDE) begin
                port_slot = k;
            end
        end
    endfunction : port_slot

    typedef enum {REG_A, REG_B, REG_C, REG_DRIVE, REG_LATCH, REG_NONE} reg_kind_t;

    // Register selected by an APB address
    function automatic reg_kind_t decode_reg(input logic [ADDR_W-1:0] addr);
        if (addr == OFF_ROUTE_A) begin
            decode_reg = REG_A;
        end else if (addr == OFF_ROUTE_B) begin
            decode_reg = REG_B;
        end else if (addr == OFF_ROUTE_C) begin
            decode_reg = REG_C;
        end else if (port_slot(addr, OFF_DRIVE_BASE) >= 0) begin
            decode_reg = REG_DRIVE;
        end else if (port_slot(addr, OFF_LATCH_BASE) >= 0) begin
            decode_reg = REG_LATCH;
        end else begin
            decode_reg = REG_NONE;
        end
    endfunction : decode_reg

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] route_select_reg_a;
        logic [PORT_W-1:0] route_select_reg_b;
        logic [PORT_W-1:0] route_select_reg_c;
        logic [NUM_PORTS-1:0][PORT_W-1:0] pin_drive_config;
        logic [NUM_PORTS-1:0][PORT_W-1:0] port_latch;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic [NUM_PINS-1:0] pin_pullup;
        logic [NUM_SIG-1:0] periph_in;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } xbar_state_t;

    xbar_state_t state;
    xbar_state_t next_state;

    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_SIG-1:0] sig_sel;
    logic [ROUTED_PINS-1:0] slot_used;
    logic [ROUTED_PINS-1:0][POS_W-1:0] slot_sig;
    logic crossbar_global_enable;
    logic weak_pullup_disable;
    logic [NUM_PINS-1:0] latch_flat;
    logic [NUM_PINS-1:0] cfg_flat;

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    pin_sync #(
        .WIDTH(NUM_PINS)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    assign crossbar_global_enable = state.route_select_reg_c[C_XBAR_EN];
    assign weak_pullup_disable = state.route_select_reg_c[C_WPU_DIS];
    assign latch_flat = state.port_latch;
    assign cfg_flat = state.pin_drive_config;

    // ----------------------------------------------------------------
    // Priority packing
    // ----------------------------------------------------------------
    always_comb begin
        int cnt;
        cnt = 0;
        slot_used = '0;
        slot_sig = '0;
        for (int s = 0; s < NUM_SIG; s++) begin
            sig_sel[s] = sig_enable(state.route_select_reg_a,
                                    state.route_select_reg_b, s);
            // SMBus holds slots 0 and 1
            // next free slot, low to high
            if (sig_sel[s] && cnt < ROUTED_PINS) begin
                slot_used[cnt] = 1'b1;
                slot_sig[cnt] = POS_W'(s);
                cnt = cnt + 1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        int sig;
        int slot;
        logic od;
        logic drv;
        logic val;
        reg_kind_t kind;
        sig = 0;
        slot = -1;
        od = 1'b0;
        drv = 1'b0;
        val = 1'b0;
        kind = REG_NONE;
        next_state = state;

        // Pin drivers
        for (int p = 0; p < NUM_PINS; p++) begin
            od = !cfg_flat[p];
            // Port driver on; open-drain lets a 1 float
            drv = 1'b1;
            val = latch_flat[p];
            // only the first three ports route
            // unrouted pins fall back to latch
            if (crossbar_global_enable && p < ROUTED_PINS && slot_used[p]) begin
                sig = int'(slot_sig[p]);
                drv = periph_drive[sig];
                val = periph_out[sig];
                if (forced_od(sig, uart_mode0)) begin
                    od = 1'b1;
                end
            end
            if (!crossbar_global_enable) begin
                next_state.pin_oe[p] = 1'b0;
                next_state.pin_out[p] = 1'b0;
            end else if (od) begin
                next_state.pin_oe[p] = drv && !val;
                next_state.pin_out[p] = 1'b0;
            end else begin
                next_state.pin_oe[p] = drv;
                next_state.pin_out[p] = val;
            end
            next_state.pin_pullup[p] = od && !weak_pullup_disable &&
                                       !(crossbar_global_enable && drv && !val);
            if (p >= BONDED_PORTS * PORT_W) begin
                next_state.pin_oe[p] = 1'b0;
                next_state.pin_out[p] = 1'b0;
                next_state.pin_pullup[p] = 1'b0;
            end
        end

        // Peripheral inputs see routed pins, idle otherwise
        next_state.periph_in = {NUM_SIG{IDLE_LEVEL}};
        for (int p = 0; p < ROUTED_PINS; p++) begin
            if (crossbar_global_enable && slot_used[p] &&
                p < BONDED_PORTS * PORT_W) begin
                next_state.periph_in[slot_sig[p]] = pin_level[p];
            end
        end

        // APB: answer prepared in setup, write taken in access
        next_state.pready = psel && !penable;
        next_state.pslverr = 1'b0;
        kind = decode_reg(paddr);
        if (psel && !penable) begin
            next_state.prdata = '0;
            case (kind)
                REG_A: begin
                    next_state.prdata[PORT_W-1:0] = state.route_select_reg_a;
                end
                REG_B: begin
                    next_state.prdata[PORT_W-1:0] = state.route_select_reg_b;
                end
                REG_C: begin
                    next_state.prdata[PORT_W-1:0] = state.route_select_reg_c;
                end
                REG_DRIVE: begin
                    slot = port_slot(paddr, OFF_DRIVE_BASE);
                    next_state.prdata[PORT_W-1:0] = state.pin_drive_config[slot];
                end
                REG_LATCH: begin
                    slot = port_slot(paddr, OFF_LATCH_BASE);
                    // live pin level, not the latch
                    next_state.prdata[PORT_W-1:0] = pin_level[slot*PORT_W +: PORT_W];
                end
                default: begin
                    next_state.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite && state.pready && !state.pslverr) begin
            case (kind)
                REG_A: begin
                    next_state.route_select_reg_a = pwdata[PORT_W-1:0];
                end
                REG_B: begin
                    next_state.route_select_reg_b = pwdata[PORT_W-1:0];
                end
                REG_C: begin
                    next_state.route_select_reg_c = pwdata[PORT_W-1:0];
                end
                REG_DRIVE: begin
                    slot = port_slot(paddr, OFF_DRIVE_BASE);
                    next_state.pin_drive_config[slot] = pwdata[PORT_W-1:0];
                end
                REG_LATCH: begin
                    slot = port_slot(paddr, OFF_LATCH_BASE);
                    next_state.port_latch[slot] = pwdata[PORT_W-1:0];
                end
                default: begin
                    // Unmapped: write dropped
                end
            endcase
        end
        if (!(psel && !penable)) begin
            next_state.pslverr = state.pslverr && psel && penable &&
                                 !state.pready;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.route_select_reg_a <= ROUTE_RESET;
            state.route_select_reg_b <= ROUTE_RESET;
            state.route_select_reg_c <= ROUTE_RESET;
            state.pin_drive_config <= {NUM_PORTS{DRIVE_RESET}};
            state.port_latch <= {NUM_PORTS{LATCH_RESET}};
            state.periph_in <= {NUM_SIG{IDLE_LEVEL}};
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign pin_out = state.pin_out;
    assign pin_oe = state.pin_oe;
    assign pin_pullup = state.pin_pullup;
    assign periph_in = state.periph_in;

endmodule : priority_crossbar_port_io

`default_nettype wire

// >>> verification/crossbar_properties.sv
// Concurrent checks on the crossbar's bus timing, drive and pull-ups.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module crossbar_checker #(
    parameter int BONDED_PORTS = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [crossbar_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crossbar_pkg::DATA_W-1:0] pwdata,
    input wire logic [crossbar_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and peripherals
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_out,
    input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_drive,
    input wire logic [crossbar_pkg::NUM_SIG-1:0] periph_in
);
    import crossbar_pkg::*;
    typedef struct packed {
        logic en;
        logic smb;
        logic wpu;
    } shadow_t;
    shadow_t sh;
    shadow_t next_sh;
    logic wr;
    logic mapped;
    assign wr = psel && penable && pready && pwrite;
    assign mapped = paddr[1:0] == 2'h0 && paddr != 8'h0c && paddr <= 8'h2c;
    // Shadow of the routing bits written over the bus
    always_comb begin
        next_sh = sh;
        if (wr && paddr == OFF_ROUTE_A) next_sh.smb = pwdata[A_SMBUS];
        if (wr && paddr == OFF_ROUTE_C) begin
            next_sh.en = pwdata[C_XBAR_EN];
            next_sh.wpu = pwdata[C_WPU_DIS];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sh <= '0;
        else sh <= next_sh;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("ready missing in access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_refused: assert property (pready && !mapped |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_mapped_clean: assert property (pready && mapped |-> !pslverr && prdata[31:8] == '0)
        else $error("mapped access flagged or upper bits set");
    a_off_all_inputs: assert property (!sh.en |=> pin_oe == '0 && periph_in == '1)
        else $error("pin driven while crossbar off");
    a_pullup_disabled: assert property (sh.wpu |=> pin_pullup == '0)
        else $error("pull-up on while disabled");
    a_pullup_low_off: assert property ((pin_pullup & pin_oe & ~pin_out) == '0)
        else $error("pull-up on a pin driving low");
    a_smbus_open_drain: assert property (sh.en && sh.smb |=>
        !(pin_oe[0] && pin_out[0]) && !(pin_oe[1] && pin_out[1]))
        else $error("bus pin driven high");
    a_smbus_first_pin: assert property (sh.en && sh.smb && periph_drive[SIG_SDA]
        && !periph_out[SIG_SDA] |=> pin_oe[0] && !pin_out[0])
        else $error("data line not on pin 0");
endmodule : crossbar_checker

bind priority_crossbar_port_io crossbar_checker #(.BONDED_PORTS(BONDED_PORTS)) i_crossbar_checker (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .periph_out(periph_out),
    .periph_drive(periph_drive), .periph_in(periph_in));
`default_nettype wire

// >>> verification/board_model.sv
// Board side of the pins: resolves each pin from all drivers.
// Assumes pin_oe high means the block drives the pin.
`timescale 1ns/1ps
`default_nettype none

module board_model (
    // Clock
    input wire logic pclk,
    // Block side
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [crossbar_pkg::NUM_PINS-1:0] pin_pullup,
    // External drivers
    input wire logic [crossbar_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [crossbar_pkg::NUM_PINS-1:0] ext_val,
    output logic [crossbar_pkg::NUM_PINS-1:0] pin_in
);
    import crossbar_pkg::*;
    // Floating pins wander every cycle
    logic [NUM_PINS-1:0] churn = 32'h5555_5555;
    always_ff @(posedge pclk) churn <= ~churn;
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en & (pin_pullup | churn));
    end
endmodule : board_model
`default_nettype wire

// >>> verification/priority_crossbar_port_io_tb.sv
// Self-checking bench for the priority crossbar.
// Assumes a board model on the pins and bench-driven peripherals.
`timescale 1ns/1ps
`default_nettype none

module priority_crossbar_port_io_tb;
    import crossbar_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, pin_in, pin_out, pin_oe, pin_pullup, rd;
    logic pready, pslverr, err;
    logic [31:0] ext_en = 32'h0;
    logic [31:0] ext_val = 32'h0;
    logic [22:0] periph_out = 23'h0;
    logic [22:0] periph_drive = 23'h0;
    logic uart_mode0 = 1'b0;
    logic [22:0] periph_in;
    int mismatches = 0;
    int tests_run = 0;

    priority_crossbar_port_io #(.BONDED_PORTS(4)) i_priority_crossbar_port_io (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .periph_out(periph_out), .periph_drive(periph_drive), .uart_mode0(uart_mode0),
        .periph_in(periph_in));
    board_model i_board_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) chk(32'h0, 32'h1, "no ready");
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rdk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask : rdk
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask : settle

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_state;
        chk(pin_oe, 32'h0, "reset enables");
        chk(pin_pullup, 32'hffffffff, "reset pull-ups");
        rdk(OFF_ROUTE_C, 32'h0, "route c reset");
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask : t_reset_state
    task automatic t_disabled;
        @(posedge pclk);
        periph_drive <= 23'h7fffff;
        wr(OFF_ROUTE_A, 8'hff);
        wr(OFF_ROUTE_B, 8'hff);
        settle();
        chk(pin_oe, 32'h0, "disabled enables");
        chk({9'h0, periph_in}, 32'h007fffff, "disabled inputs");
        rdk(OFF_ROUTE_A, 32'hff, "route readback");
    endtask : t_disabled
    task automatic t_smbus_spi;
        @(posedge pclk);
        periph_drive <= 23'h00003f;
        periph_out <= 23'h00002a;
        ext_en <= 32'h2;
        wr(OFF_DRIVE_BASE, 8'hff);
        wr(OFF_ROUTE_B, 8'h00);
        wr(OFF_LATCH_BASE, 8'hc0);
        wr(OFF_ROUTE_A, 8'h03);
        wr(OFF_ROUTE_C, 8'h40);
        settle();
        chk(pin_oe, 32'h000000fd, "bus enables");
        chk(pin_out & pin_oe, 32'h000000e8, "bus values");
        chk(pin_pullup, 32'hffffff02, "bus pull-ups");
        chk({9'h0, periph_in}, 32'h007fffe8, "bus inputs");
    endtask : t_smbus_spi
    task automatic t_uart_pack;
        @(posedge pclk);
        periph_drive <= 23'h0040c0;
        periph_out <= 23'h0040c0;
        uart_mode0 <= 1'b1;
        ext_en <= 32'h0;
        wr(OFF_LATCH_BASE, 8'hf0);
        wr(OFF_ROUTE_A, 8'h84);
        settle();
        chk(pin_oe, 32'h000000fd, "packed enables");
        chk(pin_out & pin_oe, 32'h000000f5, "packed values");
        @(posedge pclk);
        uart_mode0 <= 1'b0;
        settle();
        chk(pin_oe, 32'h000000ff, "receive push-pull");
    endtask : t_uart_pack
    task automatic t_spill;
        @(posedge pclk);
        periph_drive <= 23'h7fffff;
        periph_out <= 23'h7ffffc;
        for (int p = 0; p < 4; p++) wr(OFF_DRIVE_BASE + 8'(4 * p), 8'hff);
        wr(OFF_LATCH_BASE + 8'h08, 8'h00);
        wr(OFF_LATCH_BASE + 8'h0c, 8'ha5);
        wr(OFF_ROUTE_B, 8'hff);
        wr(OFF_ROUTE_A, 8'hef);
        settle();
        chk(pin_oe, 32'hffffffff, "full enables");
        chk(pin_out, 32'ha57ffffc, "full values");
        chk(pin_pullup, 32'h0, "push-pull pull-ups");
    endtask : t_spill
    task automatic t_pullups;
        for (int p = 1; p < 4; p++) wr(OFF_DRIVE_BASE + 8'(4 * p), 8'h00);
        wr(OFF_DRIVE_BASE, 8'h0f);
        wr(OFF_LATCH_BASE, 8'h33);
        wr(OFF_LATCH_BASE + 8'h04, 8'h0f);
        wr(OFF_LATCH_BASE + 8'h08, 8'hff);
        wr(OFF_LATCH_BASE + 8'h0c, 8'hff);
        wr(OFF_ROUTE_A, 8'h00);
        wr(OFF_ROUTE_B, 8'h00);
        settle();
        chk(pin_oe, 32'h0000f0cf, "general enables");
        chk(pin_pullup, 32'hffff0f30, "open-drain pull-ups");
        rdk(OFF_LATCH_BASE, 32'h33, "port level");
        @(posedge pclk);
        ext_en <= 32'h00ff0000;
        ext_val <= 32'h005a0000;
        wr(OFF_ROUTE_C, 8'hc0);
        settle();
        chk(pin_pullup, 32'h0, "pull-ups disabled");
        rdk(OFF_LATCH_BASE + 8'h08, 32'h5a, "external level");
        wr(OFF_ROUTE_C, 8'h80);
        settle();
        chk(pin_oe, 32'h0, "switched off");
    endtask : t_pullups

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_reset_state();
        t_disabled();
        t_smbus_spi();
        t_uart_pack();
        t_spill();
        t_pullups();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end
endmodule : priority_crossbar_port_io_tb
`default_nettype wire
